// >>> rtl/mft_defs.svh
// Purpose: Constants for the multifunction timer mode/input block
// Assumes: Included by bare name
// Notes:   Input function codes, edge selects, clear values, prescale ratio
`ifndef MFT_DEFS_SVH
`define MFT_DEFS_SVH
// ----------------------------------------
// Input function codes
// ----------------------------------------
`define MFT_IF_NONE      4'h0
`define MFT_IF_NB_TRIG   4'h1
`define MFT_IF_GA_NB     4'h2
`define MFT_IF_GA_TRIG   4'h3
`define MFT_IF_NA_CLK    4'h4
`define MFT_IF_TA_NB     4'h5
`define MFT_IF_GA_CLK    4'h6
`define MFT_IF_TA_TB     4'h7
`define MFT_IF_CLKUD     4'h8
`define MFT_IF_UDL_CLK   4'h9
`define MFT_IF_TRIGUD    4'hA
`define MFT_IF_UDL_NB    4'hB
`define MFT_IF_AUTOD     4'hC
`define MFT_IF_TA_CLK    4'hD
`define MFT_IF_CLK_TB    4'hE
`define MFT_IF_TA_GB     4'hF
// ----------------------------------------
// Edge selects, clear values, prescale ratio
// ----------------------------------------
`define MFT_EDGE_RISE    2'h1
`define MFT_EDGE_FALL    2'h2
`define MFT_EDGE_BOTH    2'h3
`define MFT_CLR_UP       16'h0000
`define MFT_CLR_DOWN     16'hFFFF
`define MFT_SYSDIV       2'h3
`define MFT_SYSDIV_LAST  2'h2
`endif

// >>> rtl/mft_pkg.sv
// Purpose: Types for the multifunction timer mode/input block
// Assumes: Nothing
// Notes:   Mode bits travel as one packed struct
package mft_pkg;
	// Mode and control bits from software
	typedef struct packed {
		logic       reg0ModeBit;
		logic       reg1ModeBit;
		logic       bivalueSelect;
		logic       oneShot;
		logic       cascadeClockSelect;
		logic       softUpDown;
		logic       clearOnCapture0;
		logic       clearOnCompare0;
		logic [3:0] inputFunctionCode;
		logic [1:0] inputAEdgeSelect;
		logic [1:0] inputBEdgeSelect;
	} mft_mode_t;
	// Reload/capture alternation pointer
	typedef enum logic {MFT_CUR_R0 = 1'b0, MFT_CUR_R1 = 1'b1} mft_cur_t;
endpackage : mft_pkg

// >>> rtl/mft_timer.sv
// Purpose: 16-bit up/down multifunction timer counting modes and input pins
// Assumes: Pins async to sys_clk; software bits synchronous
// Notes:   Prescale tick divides by three, then an 8-bit prescaler
//
// Contract
// RQ1 - Capture or bicapture mode: full range, no reload
// RQ2 - Register 1 mirrors counter when not capturing
// RQ3 - Clear gives zero up, all ones down
// RQ4 - Clear command clears counter immediately
// RQ5 - Clear on capture0 or compare0 when enabled
// RQ6 - Bivalue: reg0 mode picks reload or capture
// RQ7 - Alternating reload, register 0 first
// RQ8 - Trigger reload from register 0 restarts alternation
// RQ9 - Alternating capture, register 0 first
// RQ10 - Cascade takes first timer prescaler output
// RQ11 - Cascade prescale zero passes tick unchanged
// RQ12 - Autodiscrimination phase gives one step
// RQ13 - Per-input rising, falling or both edges
// RQ14 - Codes 0 to 7 input assignment
// RQ15 - Codes 8 to 15 input assignment
// RQ16 - Input A trigger loads or captures register 0
// RQ17 - Input B captures register 1; off in bivalue
// RQ18 - Gate enables counting only while low
// RQ19 - No inputs: internal clock, software direction
// RQ20 - Gated external clock, software direction
// RQ21 - Gate pulses last two prescaler periods
// RQ22 - Compare for N pulses is start plus N-1
// RQ23 - Prescaler fed by system clock/3 or external
// RQ24 - B edges with A low count up/down
// RQ25 - Inputs synchronised and edge detected first
`timescale 1ns/1ns
`include "mft_defs.svh"

module mft_timer
	import mft_pkg::*;
#(
	parameter int CW = 16,
	parameter int PW = 8
) (
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          sys_rst,
	// Software control
	input  wire mft_mode_t     modeBits,
	input  wire logic [PW-1:0] prescaleValue,
	input  wire logic          counterClearCmd,
	input  wire logic          softCapture0,
	input  wire logic          softCapture1,
	input  wire logic          softTrigger0,
	input  wire logic          countEnable,
	input  wire logic [CW-1:0] reloadValue0,
	input  wire logic          reloadWrite0,
	input  wire logic [CW-1:0] reloadValue1,
	input  wire logic          reloadWrite1,
	input  wire logic [CW-1:0] compareReg0,
	// Cascade link from the first timer
	input  wire logic          cascadeTickIn,
	// External pins
	input  wire logic          timerInputA,
	input  wire logic          timerInputB,
	// Status
	output logic [CW-1:0]      counterValue,
	output logic [CW-1:0]      captureLoadReg0,
	output logic [CW-1:0]      captureLoadReg1,
	output logic               countUpStatus,
	output logic               endOfCount,
	output logic               compareMatch0,
	output logic               prescaleTickOut
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Edge qualifier shared by both inputs
	function automatic logic edgeHit(input logic [1:0] sel, input logic r, input logic f);
		edgeHit = (sel[0] & r) | (sel[1] & f); // RQ13
	endfunction : edgeHit

	// Clear value depends on direction
	function automatic logic [CW-1:0] clearVal(input logic up);
		clearVal = up ? CW'(`MFT_CLR_UP) : CW'(`MFT_CLR_DOWN); // RQ3
	endfunction : clearVal

	// ----------------------------------------
	// Input synchronisers and edges
	// ----------------------------------------
	logic [2:0] syncA_q;
	logic [2:0] syncB_q;
	logic       levA_q;
	logic       levB_q;

	// Three flops; level changes only when stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			syncA_q <= 3'h0;
			syncB_q <= 3'h0;
			levA_q  <= 1'b0;
			levB_q  <= 1'b0;
		end else begin
			syncA_q <= {syncA_q[1:0], timerInputA};
			syncB_q <= {syncB_q[1:0], timerInputB};
			if (syncA_q[1] == syncA_q[2]) levA_q <= syncA_q[2]; // RQ25
			if (syncB_q[1] == syncB_q[2]) levB_q <= syncB_q[2]; // RQ25
		end
	end

	wire logic filtA = (syncA_q[1] == syncA_q[2]) ? syncA_q[2] : levA_q;
	wire logic filtB = (syncB_q[1] == syncB_q[2]) ? syncB_q[2] : levB_q;
	wire logic riseA = filtA & ~levA_q;
	wire logic fallA = ~filtA & levA_q;
	wire logic riseB = filtB & ~levB_q;
	wire logic fallB = ~filtB & levB_q;
	wire logic evA   = edgeHit(modeBits.inputAEdgeSelect, riseA, fallA);
	wire logic evB   = edgeHit(modeBits.inputBEdgeSelect, riseB, fallB);

	// ----------------------------------------
	// Input function decode
	// ----------------------------------------
	wire logic [3:0] fc  = modeBits.inputFunctionCode;
	wire logic biv       = modeBits.bivalueSelect;
	// Gate roles
	wire logic gateA     = (fc == `MFT_IF_GA_NB) | (fc == `MFT_IF_GA_TRIG) |
	                       (fc == `MFT_IF_GA_CLK); // RQ14
	wire logic gateB     = (fc == `MFT_IF_TA_GB); // RQ15
	// Trigger roles (trigger up/down excluded)
	wire logic trigARole = (fc == `MFT_IF_TA_NB) | (fc == `MFT_IF_TA_TB) |
	                       (fc == `MFT_IF_TA_CLK) | (fc == `MFT_IF_TA_GB);
	wire logic trigBRole = (fc == `MFT_IF_NB_TRIG) | (fc == `MFT_IF_GA_TRIG) |
	                       (fc == `MFT_IF_TA_TB) | (fc == `MFT_IF_CLK_TB);
	// External clock and direction roles
	wire logic extClkB   = (fc == `MFT_IF_NA_CLK) | (fc == `MFT_IF_GA_CLK) |
	                       (fc == `MFT_IF_UDL_CLK) | (fc == `MFT_IF_TA_CLK);
	wire logic extClkA   = (fc == `MFT_IF_CLK_TB);
	wire logic clkUpDn   = (fc == `MFT_IF_CLKUD);
	wire logic trigUpDn  = (fc == `MFT_IF_TRIGUD);
	wire logic udLevel   = (fc == `MFT_IF_UDL_CLK) | (fc == `MFT_IF_UDL_NB);
	wire logic autoD     = (fc == `MFT_IF_AUTOD);
	// Gate open while gate input low
	wire logic gateOpen  = ~((gateA & levA_q) | (gateB & levB_q)); // RQ18
	// Trigger events
	wire logic trigA     = trigARole & evA; // RQ16
	wire logic trigB     = trigBRole & evB & ~biv; // RQ17

	// ----------------------------------------
	// Direction
	// ----------------------------------------
	logic trigDirUp_q;
	// Pin B has priority over pin A for trigger up/down
	always_ff @(posedge sys_clk) begin
		if (sys_rst) trigDirUp_q <= 1'b1;
		else if (trigUpDn & evB) trigDirUp_q <= 1'b0;
		else if (trigUpDn & evA) trigDirUp_q <= 1'b1;
	end

	wire logic autoUp  = autoD & riseB & ~levA_q; // RQ24
	wire logic autoDn  = autoD & fallB & ~levA_q; // RQ24
	wire logic dirUp   = udLevel  ? levA_q :
	                     trigUpDn ? trigDirUp_q :
	                     clkUpDn  ? ~evB :
	                     autoD    ? autoUp :
	                     modeBits.softUpDown; // RQ19 RQ20 RQ12

	// ----------------------------------------
	// Prescaler source and divider
	// ----------------------------------------
	logic [1:0]    div3_q;
	logic [PW-1:0] pre_q;
	wire logic sysTick   = (div3_q == `MFT_SYSDIV_LAST); // RQ23
	wire logic preSrc    = modeBits.cascadeClockSelect ? cascadeTickIn : // RQ10
	                       extClkB ? (evB & gateOpen) :                 // RQ20
	                       extClkA ? evA :
	                       (sysTick & gateOpen);                        // RQ18
	wire logic preWrap   = (pre_q == prescaleValue); // RQ11
	wire logic preTick   = preSrc & preWrap;
	// Clock up/down and autodiscrimination bypass the prescaler
	wire logic stepReq   = clkUpDn ? (evA | evB) :
	                       autoD   ? (autoUp | autoDn) : preTick; // RQ12
	wire logic clearEv;
	// Divide by three then count prescale; a clear reloads the prescaler
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div3_q <= 2'h0;
			pre_q  <= '0;
		end else begin
			div3_q <= sysTick ? 2'h0 : div3_q + 2'h1;
			if (clearEv) pre_q <= '0; // RQ5
			else if (preSrc) pre_q <= preWrap ? '0 : pre_q + PW'(1);
		end
	end

	// ----------------------------------------
	// Counter, capture and reload
	// ----------------------------------------
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] r0_q;
	logic [CW-1:0] r1_q;
	logic          cur_q;
	logic          run_q;
	logic          cmpHit_q;
	logic          eoc_q;
	// Biload with register 0 in reload, bicapture with it in capture
	wire logic biLoad   = biv & ~modeBits.reg0ModeBit; // RQ6
	wire logic biCap    = biv & modeBits.reg0ModeBit;  // RQ6
	wire logic cap0Ev   = modeBits.reg0ModeBit & (softCapture0 | trigA);
	wire logic cap1Ev   = ~biv & modeBits.reg1ModeBit & (softCapture1 | trigB);
	wire logic trig0Ld  = ~modeBits.reg0ModeBit & (softTrigger0 | trigA); // RQ16
	wire logic capTo0   = cap0Ev & ~(biCap & cur_q);  // RQ9
	wire logic capTo1   = (cap0Ev & biCap & cur_q) | (cap1Ev & ~biCap); // RQ9 RQ17
	wire logic atEnd    = dirUp ? (cnt_q == '1) : (cnt_q == '0);
	wire logic doStep   = stepReq & run_q & countEnable;
	wire logic eocEv    = doStep & atEnd;
	wire logic cmpEv    = (cnt_q == compareReg0) & ~cmpHit_q;
	wire logic freeRun  = modeBits.reg0ModeBit; // RQ1
	assign clearEv      = counterClearCmd |                           // RQ4
	                      (modeBits.clearOnCapture0 & capTo0) |        // RQ5
	                      (modeBits.clearOnCompare0 & cmpEv);          // RQ5
	wire logic [CW-1:0] reloadSrc = (biLoad & cur_q) ? r1_q : r0_q;    // RQ7
	wire logic [CW-1:0] stepVal   = dirUp ? cnt_q + CW'(1) : cnt_q - CW'(1);

	// Counter with clear over trigger load over end-of-count reload
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			run_q <= 1'b1;
		end else begin
			if (clearEv) cnt_q <= clearVal(dirUp); // RQ3
			else if (trig0Ld) cnt_q <= r0_q; // RQ8
			else if (eocEv & ~freeRun & ~modeBits.oneShot) cnt_q <= reloadSrc; // RQ7
			else if (doStep) cnt_q <= stepVal; // RQ1
			if (trig0Ld) run_q <= 1'b1;
			else if (eocEv & modeBits.oneShot) run_q <= 1'b0;
		end
	end

	// Alternation pointer held at register 0 while bivalue low
	always_ff @(posedge sys_clk) begin
		if (sys_rst) cur_q <= MFT_CUR_R0;
		else if (~biv) cur_q <= MFT_CUR_R0; // RQ7 RQ9
		else if (biLoad & trig0Ld) cur_q <= MFT_CUR_R1; // RQ8
		else if (biLoad & eocEv & ~modeBits.oneShot) cur_q <= ~cur_q; // RQ7
		else if (biCap & cap0Ev) cur_q <= ~cur_q; // RQ9
	end

	// Capture/load registers; register 1 mirrors the counter in monitor mode
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r0_q <= '0;
			r1_q <= '0;
		end else begin
			if (capTo0) r0_q <= cnt_q;
			else if (reloadWrite0) r0_q <= reloadValue0;
			if (~modeBits.reg1ModeBit & ~biv) r1_q <= cnt_q; // RQ2
			else if (capTo1) r1_q <= cnt_q;
			else if (reloadWrite1) r1_q <= reloadValue1;
		end
	end

	// Compare fires once per arrival at the value
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cmpHit_q <= 1'b0;
			eoc_q    <= 1'b0;
		end else begin
			cmpHit_q <= (cnt_q == compareReg0);
			eoc_q    <= eocEv;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign counterValue    = cnt_q;
	assign captureLoadReg0 = r0_q;
	assign captureLoadReg1 = r1_q;
	assign countUpStatus   = dirUp;
	assign endOfCount      = eoc_q;
	assign compareMatch0   = cmpHit_q;
	assign prescaleTickOut = preTick; // RQ10
endmodule : mft_timer

// >>> dv/mft_timer_chk.sv
// Purpose: Port assertions for the timer mode block
// Assumes: Only the top module ports are visible
// Notes:   Bind statement follows the module
`timescale 1ns/1ns
module mft_timer_chk
	import mft_pkg::*;
#(
	parameter int CW = 16,
	parameter int PW = 8
) (
	// Clock and reset
	input wire logic          sys_clk,
	input wire logic          sys_rst,
	// Controls and pins
	input wire mft_mode_t     modeBits,
	input wire logic [PW-1:0] prescaleValue,
	input wire logic          counterClearCmd,
	input wire logic          softCapture0,
	input wire logic          softTrigger0,
	input wire logic          countEnable,
	input wire logic          cascadeTickIn,
	input wire logic          timerInputA,
	// Status
	input wire logic [CW-1:0] counterValue,
	input wire logic [CW-1:0] captureLoadReg0,
	input wire logic [CW-1:0] captureLoadReg1,
	input wire logic          countUpStatus,
	input wire logic          prescaleTickOut
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Quiet means no clear command, software trigger or clear on compare/capture can disturb the counter
	wire logic [3:0] fn      = modeBits.inputFunctionCode;
	wire logic       quiet   = !counterClearCmd && !softTrigger0 && !modeBits.clearOnCompare0
		&& !modeBits.clearOnCapture0;
	wire logic       freeRun = quiet && countEnable && fn == 4'h0 && prescaleValue == '0
		&& !modeBits.cascadeClockSelect && modeBits.reg0ModeBit && !modeBits.bivalueSelect;
	wire logic       biCap   = modeBits.bivalueSelect && modeBits.reg0ModeBit;
	wire logic       watch   = !modeBits.reg1ModeBit && !modeBits.bivalueSelect;
	sequence gateHeld;
		timerInputA[*6];
	endsequence
	property stepOnTick;
		freeRun && prescaleTickOut |=> counterValue ==
			$past(counterValue) + ($past(countUpStatus) ? 16'h0001 : 16'hFFFF);
	endproperty
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	clear_up_a : assert property (counterClearCmd && countUpStatus |=> counterValue == 16'h0000)
		else $error("Clear while counting up missed zero");
	clear_down_a : assert property (counterClearCmd && !countUpStatus |=> counterValue == 16'hFFFF)
		else $error("Clear while counting down missed all ones");
	free_step_a : assert property (stepOnTick)
		else $error("Counter did not step by one on a tick");
	soft_dir_a : assert property (fn == 4'h0 |-> countUpStatus == modeBits.softUpDown)
		else $error("Direction not under software control");
	monitor_a : assert property (watch && $past(watch) |-> captureLoadReg1 == counterValue
		|| captureLoadReg1 == $past(counterValue)) else $error("Register 1 not mirroring");
	gate_hold_a : assert property (gateHeld ##0 (quiet && (fn == 4'h2 || fn == 4'h6))
		|=> $stable(counterValue)) else $error("Counter moved with gate high");
	bicap_a : assert property (softCapture0 && biCap |=> captureLoadReg0 == $past(counterValue)
		|| captureLoadReg1 == $past(counterValue)) else $error("Bicapture stored nothing");
	clr_cap_a : assert property (softCapture0 && modeBits.reg0ModeBit &&
		modeBits.clearOnCapture0 && countUpStatus |=> counterValue == 16'h0000)
		else $error("Capture did not clear counter");
	cascade_a : assert property (modeBits.cascadeClockSelect && prescaleValue == '0 &&
		countEnable && fn == 4'h0 |-> prescaleTickOut == cascadeTickIn)
		else $error("Cascade tick not passed through");
endmodule : mft_timer_chk

bind mft_timer mft_timer_chk #(.CW(CW), .PW(PW)) chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .modeBits(modeBits),
	.prescaleValue(prescaleValue), .counterClearCmd(counterClearCmd),
	.softCapture0(softCapture0), .softTrigger0(softTrigger0), .countEnable(countEnable),
	.cascadeTickIn(cascadeTickIn), .timerInputA(timerInputA), .counterValue(counterValue),
	.captureLoadReg0(captureLoadReg0), .captureLoadReg1(captureLoadReg1),
	.countUpStatus(countUpStatus), .prescaleTickOut(prescaleTickOut));

// >>> dv/mft_pin_src.sv
// Purpose: External signal source for the two timer pins
// Assumes: Tasks are called just after a rising edge
// Notes:   Pins are always driven, never released
`timescale 1ns/1ns
module mft_pin_src (
	// Clock
	input wire logic sys_clk,
	// Driven pins
	output logic     timerInputA,
	output logic     timerInputB
);
	// Each level lasts seven cycles, over two prescaler periods, so it also suits a gate
	task automatic level(input bit pinB, input bit v);
		@(posedge sys_clk);
		if (pinB) timerInputB <= v;
		else timerInputA <= v;
		repeat (6) @(posedge sys_clk);
	endtask : level
	task automatic pulse(input bit pinB);
		level(pinB, 1'b1);
		level(pinB, 1'b0);
	endtask : pulse
	initial begin
		timerInputA = 1'b0;
		timerInputB = 1'b0;
	end
endmodule : mft_pin_src

// >>> dv/mft_timer_tb_top.sv
// Purpose: Self-checking bench for the timer mode block
// Assumes: Software bits change just after a rising edge
// Notes:   Driver queues notes, a negedge monitor compares them
`timescale 1ns/1ns
module mft_timer_tb_top
	import mft_pkg::*;
;
	typedef struct packed {logic [3:0] code; logic [1:0] bEdge; logic aHigh; logic cas;
		logic [15:0] cnt;} mft_row_t;
	typedef struct {int sel; logic [15:0] val; int due;} mft_note_t;
	// ----------------------------------------
	// Stimulus and status
	// ----------------------------------------
	logic        sys_clk = 1'b0, sys_rst = 1'b1, counterClearCmd = 1'b0, softCapture0 = 1'b0;
	logic        countEnable = 1'b0, reloadWrite1 = 1'b0, cascadeTickIn = 1'b0;
	logic [15:0] reloadValue1 = 16'h0000;
	// Held controls stay variables so a later scenario can move them
	logic [7:0]  prescaleValue = 8'h00;
	logic        softTrigger0 = 1'b0;
	logic [15:0] compareReg0 = 16'hFFFF;
	mft_mode_t   mode = '0;
	wire logic   timerInputA, timerInputB, countUpStatus, prescaleTickOut;
	wire logic [15:0] counterValue, captureLoadReg0, captureLoadReg1;
	int          cyc = 0, mismatches = 0, num_checks = 0;
	mft_note_t   notes[$];
	string       nm[3] = '{"counter", "reg0", "reg1"};
	// Clock sources: code, edge on B, A level, cascade, expected count
	mft_row_t    rows[6] = '{'{4'h4, 2'h1, 1'b0, 1'b0, 16'h0003},
		'{4'h4, 2'h2, 1'b0, 1'b0, 16'h0003}, '{4'h4, 2'h3, 1'b0, 1'b0, 16'h0006},
		'{4'h6, 2'h1, 1'b1, 1'b0, 16'h0000}, '{4'h6, 2'h1, 1'b0, 1'b0, 16'h0003},
		'{4'h0, 2'h1, 1'b0, 1'b1, 16'h0003}};
	always #2 sys_clk = ~sys_clk;
	mft_timer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .modeBits(mode),
		.prescaleValue(prescaleValue),
		.counterClearCmd(counterClearCmd), .softCapture0(softCapture0), .softCapture1(1'b0),
		.softTrigger0(softTrigger0), .countEnable(countEnable), .reloadValue0(~reloadValue1),
		.reloadWrite0(reloadWrite1), .reloadValue1(reloadValue1), .reloadWrite1(reloadWrite1),
		.compareReg0(compareReg0), .cascadeTickIn(cascadeTickIn), .timerInputA(timerInputA),
		.timerInputB(timerInputB), .counterValue(counterValue), .captureLoadReg0(captureLoadReg0),
		.captureLoadReg1(captureLoadReg1), .countUpStatus(countUpStatus), .endOfCount(),
		.compareMatch0(), .prescaleTickOut(prescaleTickOut));
	mft_pin_src src (.sys_clk(sys_clk), .timerInputA(timerInputA), .timerInputB(timerInputB));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : step
	task automatic note(input int sel, input logic [15:0] val, input int dly);
		notes.push_back('{sel, val, cyc + dly});
	endtask : note
	task automatic clearDir(input logic up);
		mode.softUpDown <= up;
		step(1);
		counterClearCmd <= 1'b1;
		note(0, up ? 16'h0000 : 16'hFFFF, 2);
		step(1);
		counterClearCmd <= 1'b0;
	endtask : clearDir
	task automatic capture(input logic up, input logic [15:0] e0, input logic [15:0] e1);
		clearDir(up);
		softCapture0 <= 1'b1;
		note(1, e0, 2);
		note(2, e1, 2);
		step(1);
		softCapture0 <= 1'b0;
	endtask : capture
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	// Monitor compares each note in the cycle it falls due; notes are queued in order
	always @(negedge sys_clk) begin
		mft_note_t   n;
		logic [15:0] got;
		while (notes.size() != 0 && notes[0].due <= cyc) begin
			n = notes.pop_front();
			got = n.sel == 0 ? counterValue : n.sel == 1 ? captureLoadReg0 : captureLoadReg1;
			num_checks++;
			if (got !== n.val) begin
				mismatches++;
				$display("CHECK FAILED %s expected %h seen %h", nm[n.sel], n.val, got);
			end
		end
	end
	// Cycle count and hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] r1;
		void'($urandom(32'hF5D0B687));
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		mode.reg0ModeBit <= 1'b1;
		countEnable <= 1'b1;
		repeat (4) clearDir(1'($urandom));
		countEnable <= 1'b0;
		clearDir(1'b0);
		note(2, 16'hFFFF, 2);
		// Let the mirror take the cleared count before register 1 leaves monitor mode
		step(1);
		r1 = {4'h5, 12'($urandom)};
		mode.reg1ModeBit <= 1'b1;
		reloadValue1 <= r1;
		reloadWrite1 <= 1'b1;
		step(1);
		reloadWrite1 <= 1'b0;
		mode.bivalueSelect <= 1'b1;
		capture(1'b1, 16'h0000, r1);
		capture(1'b0, 16'h0000, 16'hFFFF);
		capture(1'b0, 16'hFFFF, 16'hFFFF);
		mode.bivalueSelect <= 1'b0;
		mode.clearOnCapture0 <= 1'b1;
		mode.softUpDown <= 1'b1;
		countEnable <= 1'b1;
		step(9);
		softCapture0 <= 1'b1;
		note(0, 16'h0000, 2);
		step(1);
		softCapture0 <= 1'b0;
		mode.clearOnCapture0 <= 1'b0;
		countEnable <= 1'b0;
		mode.inputFunctionCode <= 4'h7;
		mode.inputAEdgeSelect <= 2'h1;
		mode.inputBEdgeSelect <= 2'h1;
		clearDir(1'b1);
		src.pulse(1'b0);
		note(1, 16'h0000, 1);
		src.pulse(1'b1);
		note(2, 16'h0000, 1);
		clearDir(1'b0);
		mode.bivalueSelect <= 1'b1;
		src.pulse(1'b1);
		note(2, 16'h0000, 1);
		mode.bivalueSelect <= 1'b0;
		countEnable <= 1'b1;
		foreach (rows[i]) begin
			mode.inputFunctionCode <= rows[i].code;
			mode.inputBEdgeSelect <= rows[i].bEdge;
			mode.cascadeClockSelect <= rows[i].cas;
			src.level(1'b0, rows[i].aHigh);
			clearDir(1'b1);
			repeat (3) begin
				if (rows[i].cas) begin
					cascadeTickIn <= 1'b1;
					step(1);
					cascadeTickIn <= 1'b0;
					step(3);
				end else begin
					src.pulse(1'b1);
				end
			end
			step(6);
			note(0, rows[i].cnt, 1);
		end
		step(4);
		end_of_test();
	end
endmodule : mft_timer_tb_top
